// ---- hw/rxfee_params.svh ----
// Offsets, field positions, reset values and counts of the receive control block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef RXFEE_PARAMS_SVH
`define RXFEE_PARAMS_SVH

// ----------------------------------------
// Register addresses (7-bit)
// ----------------------------------------
`define RXFEE_ADDR_MAIN 7'h00
`define RXFEE_ADDR_MODSEL 7'h01
`define RXFEE_ADDR_FILTER_CLOCK_DIVIDER 7'h08
`define RXFEE_ADDR_FECTL 7'h15
`define RXFEE_ADDR_FERES 7'h16

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RXFEE_AMP_BYPASS_BIT 7
`define RXFEE_MODE_HI_BIT 2
`define RXFEE_MODE_LO_BIT 1
`define RXFEE_SIGNAL_STRENGTH_ENABLE_BIT 3
`define RXFEE_PF_HI_BIT 1
`define RXFEE_PF_LO_BIT 0
`define RXFEE_DIV_HI_BIT 5
`define RXFEE_DOUBLE_BIT 6
`define RXFEE_EST_LEN_HI_BIT 3
`define RXFEE_EST_LEN_LO_BIT 2
`define RXFEE_EST_MODE_HI_BIT 1
`define RXFEE_EST_MODE_LO_BIT 0

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define RXFEE_RST_MAIN 8'h00
`define RXFEE_RST_MODSEL 8'h00
`define RXFEE_RST_FILTER_CLOCK_DIVIDER 8'h84
`define RXFEE_RST_FECTL 8'h00
`define RXFEE_RX_MODE 2'h2
`define RXFEE_FECTL_MASK 8'h0f

// ----------------------------------------
// Counts
// ----------------------------------------
`define RXFEE_HDR_BITS 5'h08
`define RXFEE_FRAME_BITS 5'h10
`define RXFEE_PHASES 2'h3
`define RXFEE_LEN_8 7'h08
`define RXFEE_LEN_16 7'h10
`define RXFEE_LEN_32 7'h20
`define RXFEE_LEN_64 7'h40

`endif

// ---- hw/rxfee_pkg.sv ----
// Types shared by the receive control block.
// Assumes the params header is compiled alongside.
package rxfee_pkg;

  typedef enum logic [3:0] {
    RXFEE_SP_IDLE = 4'h1,
    RXFEE_SP_HDR = 4'h2,
    RXFEE_SP_WR = 4'h4,
    RXFEE_SP_RD = 4'h8
  } rxfee_sp_state_t;

  typedef enum logic [1:0] {
    RXFEE_EST_OFF = 2'h1,
    RXFEE_EST_RUN = 2'h2
  } rxfee_est_state_t;

endpackage

// ---- hw/rxfee_est_if.sv ----
// Carrier between the register side and the frequency error estimator.
// Assumes one clock domain; all signals are synchronous to it.
`timescale 1ns/1ps

interface rxfee_est_if;
  logic [1:0] mode;
  logic [1:0] len_sel;
  logic up_pulse;
  logic zero_update_pulse;
  logic symbol_tick;
  logic restart;
  logic [7:0] result;

  modport ctl (
    output mode, len_sel, up_pulse, zero_update_pulse, symbol_tick, restart,
    input result
  );
  modport est (
    input mode, len_sel, up_pulse, zero_update_pulse, symbol_tick, restart,
    output result
  );
endinterface

// ---- hw/rxfee_estimator.sv ----
// Frequency error estimator: signed pulse count over a set number of symbols.
// Assumes pulses and symbol ticks are one-cycle strobes on the same clock.
`timescale 1ns/1ps
`include "rxfee_params.svh"

module rxfee_estimator
  import rxfee_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  rxfee_est_if.est bus
);

  // ----------------------------------------
  // Length decode
  // ----------------------------------------
  function automatic logic [6:0] rxfee_len(input logic [1:0] sel);
    case (sel)
      2'h0: rxfee_len = `RXFEE_LEN_8;
      2'h1: rxfee_len = `RXFEE_LEN_16;
      2'h2: rxfee_len = `RXFEE_LEN_32;
      default: rxfee_len = `RXFEE_LEN_64;
    endcase
  endfunction

  rxfee_est_state_t state_r;
  logic [7:0] count_r;
  logic [6:0] sym_r;
  logic [7:0] result_r;
  logic [7:0] count_nxt;
  logic last_sym;

  // Bit0 enables up counting, bit1 down counting; both gives up minus down
  always_comb
  begin
    count_nxt = count_r;
    if (bus.mode[0] && bus.up_pulse)
    begin
      count_nxt = count_nxt + 8'h01; // R07
    end
    if (bus.mode[1] && bus.zero_update_pulse)
    begin
      count_nxt = count_nxt - 8'h01; // R10
    end
  end

  assign last_sym = bus.symbol_tick && ((sym_r + 7'h01) == rxfee_len(bus.len_sel)); // R08

  // ----------------------------------------
  // Measurement sequencing
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= RXFEE_EST_OFF;
      count_r <= 8'h00;
      sym_r <= 7'h00;
    end
    else
    begin
      case (state_r)
        RXFEE_EST_OFF:
        begin
          count_r <= 8'h00;
          sym_r <= 7'h00;
          if (bus.mode != 2'h0)
          begin
            state_r <= RXFEE_EST_RUN;
          end
        end
        RXFEE_EST_RUN:
        begin
          if (bus.mode == 2'h0)
          begin
            state_r <= RXFEE_EST_OFF;
          end
          else if (bus.restart || last_sym)
          begin
            count_r <= 8'h00; // R13
            sym_r <= 7'h00;
          end
          else
          begin
            count_r <= count_nxt;
            if (bus.symbol_tick)
            begin
              sym_r <= sym_r + 7'h01;
            end
          end
        end
        default:
        begin
          state_r <= RXFEE_EST_OFF;
        end
      endcase
    end
  end

  // Result holds until the next full measurement; pulse of the last cycle counts
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      result_r <= 8'h00;
    end
    else if (state_r == RXFEE_EST_RUN && bus.mode != 2'h0 && !bus.restart && last_sym)
    begin
      result_r <= count_nxt; // R13
    end
  end

  assign bus.result = result_r;

endmodule

// ---- hw/rxfee_top.sv ----
// Receive path control: three-wire register port, demodulator decision,
// switched-capacitor filter clock phases and the frequency error estimator.
// Assumes all inputs are synchronous to clk_i, the crystal oscillator clock.
//
// Overview of operation
// R01: I lagging Q gives data one, leading gives zero, on receive data pin.
// R02: Amplifier bypass bit in main control routes input around the amplifier.
// R03: Two-bit prefilter field selects 100, 150, 230 or 340 kHz cutoff.
// R04: Six-bit divider on crystal clock, then divide by four into phases.
// R05: Filter clock is twenty times cutoff; cutoff is crystal over eighty times divider.
// R06: Each updated one gives an up pulse, each updated zero a down pulse.
// R07: Mode bits: off, count up, count down, or up minus down.
// R08: Length bits select 8, 16, 32 or 64 symbols per measurement.
// R09: Host reads the 8-bit result from the estimator result register.
// R10: Negative results are two's complement, only from down-counting modes.
// R11: Host should prefer the up-minus-down mode for best accuracy.
// R12: All registers are written and read back over the three-wire port; writes to the result register are ignored.
// R13: Counter clears, accumulates over the length, latches result, holds it.
// R14: Host writes filter clock register with bit 7 one and bit 6 zero.
`timescale 1ns/1ps
`include "rxfee_params.svh"

module rxfee_top
  import rxfee_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic prog_clk_i,
  input wire logic prog_en_i,
  input wire logic prog_data_i,
  output logic prog_data_o,
  output logic prog_data_oe_o,
  input wire logic i_chan_i,
  input wire logic q_chan_i,
  input wire logic symbol_tick_i,
  output logic rx_data_o,
  output logic rx_data_oe_o,
  output logic amp_bypass_o,
  output logic [1:0] prefilter_cutoff_o,
  output logic signal_strength_enable_o,
  output logic filter_phase1_o,
  output logic filter_phase2_o
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ----------------------------------------
  // Three-wire programming port
  // ----------------------------------------
  rxfee_sp_state_t sp_state_r;
  logic pclk_d_r;
  logic [4:0] bit_cnt_r;
  logic [7:0] hdr_r;
  logic [7:0] wr_shift_r;
  logic [7:0] rd_data_r;
  logic [2:0] rd_idx_r;
  logic pclk_rise;
  logic pclk_fall;
  logic wr_commit;
  logic [7:0] wr_word;

  logic [7:0] main_r;
  logic [7:0] modsel_r;
  logic [7:0] filter_clock_divider_r;
  logic [7:0] fectl_r;

  rxfee_est_if est_bus ();

  assign pclk_rise = prog_clk_i && !pclk_d_r;
  assign pclk_fall = !prog_clk_i && pclk_d_r;
  assign wr_word = {wr_shift_r[6:0], prog_data_i};
  assign wr_commit = (sp_state_r == RXFEE_SP_WR) && pclk_rise && prog_en_i &&
                     (bit_cnt_r == `RXFEE_FRAME_BITS - 5'h01);

  // Read mux; unmapped addresses read as zero
  function automatic logic [7:0] rxfee_rd_mux(input logic [6:0] addr,
                                              input logic [7:0] m,
                                              input logic [7:0] s,
                                              input logic [7:0] c,
                                              input logic [7:0] f,
                                              input logic [7:0] r);
    case (addr)
      `RXFEE_ADDR_MAIN: rxfee_rd_mux = m;
      `RXFEE_ADDR_MODSEL: rxfee_rd_mux = s;
      `RXFEE_ADDR_FILTER_CLOCK_DIVIDER: rxfee_rd_mux = c;
      `RXFEE_ADDR_FECTL: rxfee_rd_mux = f;
      `RXFEE_ADDR_FERES: rxfee_rd_mux = r;
      default: rxfee_rd_mux = 8'h00;
    endcase
  endfunction

  always_ff @(posedge clk_i or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      pclk_d_r <= 1'b0;
    end
    else
    begin
      pclk_d_r <= prog_clk_i;
    end
  end

  // Frame: 7 address bits and a read flag, MSB first, then 8 data bits
  always_ff @(posedge clk_i or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      sp_state_r <= RXFEE_SP_IDLE;
      bit_cnt_r <= 5'h00;
      hdr_r <= 8'h00;
      wr_shift_r <= 8'h00;
      rd_data_r <= 8'h00;
      rd_idx_r <= 3'h7;
    end
    else if (!prog_en_i)
    begin
      sp_state_r <= RXFEE_SP_IDLE;
      bit_cnt_r <= 5'h00;
    end
    else
    begin
      case (sp_state_r)
        RXFEE_SP_IDLE:
        begin
          sp_state_r <= RXFEE_SP_HDR;
          bit_cnt_r <= 5'h00;
        end
        RXFEE_SP_HDR:
        begin
          if (pclk_rise)
          begin
            hdr_r <= {hdr_r[6:0], prog_data_i};
            bit_cnt_r <= bit_cnt_r + 5'h01;
            if (bit_cnt_r == `RXFEE_HDR_BITS - 5'h01)
            begin
              if (prog_data_i)
              begin
                sp_state_r <= RXFEE_SP_RD;
                rd_idx_r <= 3'h7;
                rd_data_r <= rxfee_rd_mux(hdr_r[6:0], main_r, modsel_r, filter_clock_divider_r,
                                          fectl_r, est_bus.result); // R12
              end
              else
              begin
                sp_state_r <= RXFEE_SP_WR;
              end
            end
          end
        end
        RXFEE_SP_WR:
        begin
          if (pclk_rise)
          begin
            wr_shift_r <= wr_word;
            bit_cnt_r <= bit_cnt_r + 5'h01;
            if (wr_commit)
            begin
              sp_state_r <= RXFEE_SP_IDLE;
            end
          end
        end
        RXFEE_SP_RD:
        begin
          if (pclk_rise)
          begin
            rd_idx_r <= rd_idx_r - 3'h1;
            if (rd_idx_r == 3'h0)
            begin
              sp_state_r <= RXFEE_SP_IDLE;
            end
          end
        end
        default:
        begin
          sp_state_r <= RXFEE_SP_IDLE;
        end
      endcase
    end
  end

  // Read data changes on the falling edge so the host can sample on rising
  always_ff @(posedge clk_i or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      prog_data_o <= 1'b0;
      prog_data_oe_o <= 1'b0;
    end
    else if (sp_state_r == RXFEE_SP_RD && prog_en_i)
    begin
      prog_data_oe_o <= 1'b1;
      if (pclk_fall)
      begin
        prog_data_o <= rd_data_r[rd_idx_r]; // R09
      end
    end
    else
    begin
      prog_data_oe_o <= 1'b0;
      prog_data_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  // Fixed bits of the divider register are stored as written; the host keeps them
  always_ff @(posedge clk_i or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      main_r <= `RXFEE_RST_MAIN;
      modsel_r <= `RXFEE_RST_MODSEL;
      filter_clock_divider_r <= `RXFEE_RST_FILTER_CLOCK_DIVIDER;
      fectl_r <= `RXFEE_RST_FECTL;
    end
    else if (wr_commit)
    begin
      case (hdr_r[7:1])
        `RXFEE_ADDR_MAIN: main_r <= wr_word; // R12
        `RXFEE_ADDR_MODSEL: modsel_r <= wr_word;
        `RXFEE_ADDR_FILTER_CLOCK_DIVIDER: filter_clock_divider_r <= wr_word; // R14
        `RXFEE_ADDR_FECTL: fectl_r <= wr_word & `RXFEE_FECTL_MASK;
        default: main_r <= main_r;
      endcase
    end
  end

  // Restart a measurement whenever its control changes
  logic est_restart_r;

  always_ff @(posedge clk_i or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      est_restart_r <= 1'b0;
    end
    else
    begin
      est_restart_r <= wr_commit && (hdr_r[7:1] == `RXFEE_ADDR_FECTL); // R13
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      amp_bypass_o <= 1'b0;
      prefilter_cutoff_o <= 2'h0;
      signal_strength_enable_o <= 1'b0;
      rx_data_oe_o <= 1'b0;
    end
    else
    begin
      amp_bypass_o <= main_r[`RXFEE_AMP_BYPASS_BIT]; // R02
      prefilter_cutoff_o <= modsel_r[`RXFEE_PF_HI_BIT:`RXFEE_PF_LO_BIT]; // R03
      signal_strength_enable_o <= modsel_r[`RXFEE_SIGNAL_STRENGTH_ENABLE_BIT];
      rx_data_oe_o <= main_r[`RXFEE_MODE_HI_BIT:`RXFEE_MODE_LO_BIT] == `RXFEE_RX_MODE;
    end
  end

  // ----------------------------------------
  // Demodulator decision
  // ----------------------------------------
  // Decided at each rising I edge: Q already high means I lags
  logic i_d_r;
  logic up_r;
  logic dn_r;

  always_ff @(posedge clk_i or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      i_d_r <= 1'b0;
      rx_data_o <= 1'b0;
      up_r <= 1'b0;
      dn_r <= 1'b0;
    end
    else
    begin
      i_d_r <= i_chan_i;
      up_r <= 1'b0;
      dn_r <= 1'b0;
      if (i_chan_i && !i_d_r)
      begin
        rx_data_o <= q_chan_i; // R01
        up_r <= q_chan_i; // R06
        dn_r <= !q_chan_i; // R06
      end
    end
  end

  // ----------------------------------------
  // Switched-capacitor filter clock
  // ----------------------------------------
  // A divider of zero acts as one; phases never overlap by one quarter gap
  logic [5:0] div_cnt_r;
  logic [1:0] phase_r;
  logic div_tick;
  logic [6:0] div_next;

  assign div_next = {1'b0, div_cnt_r} + 7'h01;
  assign div_tick = div_next >= {1'b0, filter_clock_divider_r[`RXFEE_DIV_HI_BIT:0]};

  always_ff @(posedge clk_i or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      div_cnt_r <= 6'h00;
      phase_r <= 2'h0;
      filter_phase1_o <= 1'b0;
      filter_phase2_o <= 1'b0;
    end
    else
    begin
      div_cnt_r <= div_tick ? 6'h00 : div_next[5:0]; // R04
      if (div_tick)
      begin
        phase_r <= (phase_r == `RXFEE_PHASES) ? 2'h0 : phase_r + 2'h1; // R05
      end
      filter_phase1_o <= phase_r == 2'h0;
      filter_phase2_o <= phase_r == 2'h2;
    end
  end

  // ----------------------------------------
  // Frequency error estimator
  // ----------------------------------------
  assign est_bus.mode = fectl_r[`RXFEE_EST_MODE_HI_BIT:`RXFEE_EST_MODE_LO_BIT]; // R07
  assign est_bus.len_sel = fectl_r[`RXFEE_EST_LEN_HI_BIT:`RXFEE_EST_LEN_LO_BIT]; // R08
  assign est_bus.up_pulse = up_r;
  assign est_bus.zero_update_pulse = dn_r;
  assign est_bus.symbol_tick = symbol_tick_i;
  assign est_bus.restart = est_restart_r;

  rxfee_estimator rxfee_estimator_i (
    .clk_i(clk_i),
    .rst_n_i(rst_sync_r),
    .bus(est_bus.est)
  );

endmodule

// ---- tb/rxfee_top_asserts.sv ----
// Checker for the receive control block, bound to its top module.
// Assumes one clock domain and the active-low pin reset of the top.
`timescale 1ns/1ps

module rxfee_top_asserts (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic prog_clk_i,
  input wire logic prog_en_i,
  input wire logic prog_data_o,
  input wire logic prog_data_oe_o,
  input wire logic i_chan_i,
  input wire logic q_chan_i,
  input wire logic rx_data_o,
  input wire logic amp_bypass_o,
  input wire logic [1:0] prefilter_cutoff_o,
  input wire logic filter_phase1_o,
  input wire logic filter_phase2_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------
  // Demodulator
  // ----------------------------------------
  // Q held steady across the I edge, so the decision is unambiguous
  sequence s_i_rise(logic v);
    $rose(i_chan_i) && q_chan_i == v && $past(q_chan_i) == v;
  endsequence

  a_demod_one: assert property (s_i_rise(1'b1) |-> ##[1:3] rx_data_o)
    else $error("data one missing after I rise");
  a_demod_zero: assert property (s_i_rise(1'b0) |-> ##[1:3] !rx_data_o)
    else $error("data zero missing after I rise");

  // ----------------------------------------
  // Filter clock phases
  // ----------------------------------------
  a_phase_excl: assert property (!(filter_phase1_o && filter_phase2_o))
    else $error("filter phases overlap");
  a_phase_order: assert property ($rose(filter_phase2_o) |-> !$past(filter_phase1_o))
    else $error("phase two follows phase one with no gap");

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  a_oe_idle: assert property (!prog_en_i && !$past(prog_en_i) && !$past(prog_en_i, 2)
    |-> !prog_data_oe_o)
    else $error("read driver on outside a frame");
  a_oe_in_frame: assert property ($rose(prog_data_oe_o) |-> $past(prog_en_i))
    else $error("read driver rose without frame");
  a_dout_idle: assert property (!prog_data_oe_o && !$past(prog_data_oe_o) |-> !prog_data_o)
    else $error("read data not low while idle");
  a_dout_on_fall: assert property (prog_data_oe_o && $changed(prog_data_o)
    |-> !$past(prog_clk_i) || !$past(prog_clk_i, 2))
    else $error("read data changed without a port clock fall");
  a_cfg_in_frame: assert property ($changed(amp_bypass_o) || $changed(prefilter_cutoff_o)
    |-> $past(prog_en_i, 2))
    else $error("configuration changed outside a write frame");
endmodule

// ---- tb/rxfee_host_model.sv ----
// Host controller on the three-wire register port: frame driver tasks.
// Assumes clk_i is the device clock; lines change 1 ns after its rising edge.
`timescale 1ns/1ps

module rxfee_host_model (
  input wire logic clk_i,
  output logic prog_clk_o,
  output logic prog_en_o,
  output logic prog_data_o,
  input wire logic prog_data_i
);
  initial
  begin
    prog_clk_o = 1'b0;
    prog_en_o = 1'b0;
    prog_data_o = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Three clocks per level keeps the two-clock minimum with margin
  task automatic pulse(input logic b, output logic s);
    prog_data_o = b;
    cyc(3);
    s = prog_data_i;
    prog_clk_o = 1'b1;
    cyc(3);
    prog_clk_o = 1'b0;
  endtask

  // Released data line toggles during reads so stale levels never look valid
  task automatic frame(input logic [6:0] a, input logic rd, input logic [7:0] d,
                       output logic [7:0] q);
    logic s;
    prog_en_o = 1'b1;
    cyc(3);
    for (int i = 6; i >= 0; i--) pulse(a[i], s);
    pulse(rd, s);
    for (int i = 7; i >= 0; i--)
    begin
      pulse(rd ? logic'(i[0]) : d[i], s);
      q[i] = s;
    end
    prog_en_o = 1'b0;
    cyc(3);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    frame(a, 1'b0, d, q);
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] q);
    frame(a, 1'b1, 8'h00, q);
  endtask
endmodule

// ---- tb/tb_rx_config_freq_error_estimator.sv ----
// Self-checking bench for the receive control block.
// Assumes the host model drives the register port; bench drives I, Q and ticks.
`timescale 1ns/1ps
`include "rxfee_params.svh"

module tb_rx_config_freq_error_estimator;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic pclk, pen, pdin, pdout, poe, i_chan, q_chan, tick;
  logic rx, rx_oe, amp, rssi, ph1, ph2;
  logic [1:0] pf;
  int failures = 0;
  int total_checks = 0;

  always #20 clk_i = ~clk_i;

  rxfee_host_model rxfee_host_model_i (.clk_i(clk_i), .prog_clk_o(pclk), .prog_en_o(pen),
    .prog_data_o(pdin), .prog_data_i(pdout));

  rxfee_top rxfee_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .prog_clk_i(pclk),
    .prog_en_i(pen), .prog_data_i(pdin), .prog_data_o(pdout), .prog_data_oe_o(poe),
    .i_chan_i(i_chan), .q_chan_i(q_chan), .symbol_tick_i(tick), .rx_data_o(rx),
    .rx_data_oe_o(rx_oe), .amp_bypass_o(amp), .prefilter_cutoff_o(pf),
    .signal_strength_enable_o(rssi), .filter_phase1_o(ph1), .filter_phase2_o(ph2));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rdchk(input string name, input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] q;
    rxfee_host_model_i.rd(a, q);
    chk(name, exp, q);
  endtask

  task automatic sym(input int ups, input int dns);
    for (int k = 0; k < ups + dns; k++)
    begin
      q_chan = (k < ups);
      cyc(2);
      i_chan = 1'b1;
      cyc(2);
      i_chan = 1'b0;
    end
    cyc(2);
    tick = 1'b1;
    cyc(1);
    tick = 1'b0;
    cyc(2);
  endtask

  task automatic ph_rise(output int n);
    logic last;
    last = ph1;
    for (n = 1; n < 300; n++)
    begin
      cyc(1);
      if (ph1 === 1'b1 && last === 1'b0)
        break;
      last = ph1;
    end
  endtask

  task test_done;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [7:0] ctl[4] = '{8'h01, 8'h06, 8'h0b, 8'h0f};
    logic [7:0] res[4] = '{8'h08, 8'hf0, 8'h20, 8'hc0};
    int nsym[4] = '{8, 16, 32, 64};
    int ups[4] = '{1, 1, 2, 0};
    logic [7:0] prev;
    int n;
    i_chan = 1'b0;
    q_chan = 1'b0;
    tick = 1'b0;
    repeat (10) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    cyc(6);
    rdchk("main", `RXFEE_ADDR_MAIN, `RXFEE_RST_MAIN);
    rdchk("modsel", `RXFEE_ADDR_MODSEL, `RXFEE_RST_MODSEL);
    rdchk("filter_clock_divider", `RXFEE_ADDR_FILTER_CLOCK_DIVIDER, `RXFEE_RST_FILTER_CLOCK_DIVIDER);
    rdchk("fectl", `RXFEE_ADDR_FECTL, `RXFEE_RST_FECTL);
    rdchk("result", `RXFEE_ADDR_FERES, 8'h00);
    // Bypass on with receive mode, then bypass off in standby
    rxfee_host_model_i.wr(`RXFEE_ADDR_MAIN, 8'h84);
    cyc(2);
    chk("amp_bypass", 8'h01, amp);
    chk("rx_oe", 8'h01, rx_oe);
    rdchk("main", `RXFEE_ADDR_MAIN, 8'h84);
    rxfee_host_model_i.wr(`RXFEE_ADDR_MAIN, 8'h02);
    cyc(2);
    chk("amp_bypass", 8'h00, amp);
    chk("rx_oe", 8'h00, rx_oe);
    for (int c = 0; c < 4; c++)
    begin
      rxfee_host_model_i.wr(`RXFEE_ADDR_MODSEL, 8'(c) | 8'(8 * (c % 2)));
      cyc(2);
      chk("prefilter", 8'(c), {6'h00, pf});
      chk("signal_strength_enable", 8'(c % 2), rssi);
    end
    // Read-only, masked and unmapped places
    rxfee_host_model_i.wr(`RXFEE_ADDR_FERES, 8'h5a);
    rdchk("result", `RXFEE_ADDR_FERES, 8'h00);
    rxfee_host_model_i.wr(`RXFEE_ADDR_FECTL, 8'hf0);
    rdchk("fectl", `RXFEE_ADDR_FECTL, 8'hf0 & `RXFEE_FECTL_MASK);
    rdchk("unmapped", 7'h02, 8'h00);
    for (int d = 2; d < 4; d++)
    begin
      rxfee_host_model_i.wr(`RXFEE_ADDR_FILTER_CLOCK_DIVIDER, 8'h80 | 8'(d));
      ph_rise(n);
      ph_rise(n);
      chk("phase_period", 8'(4 * d), 8'(n));
    end
    for (int v = 1; v >= 0; v--)
    begin
      q_chan = v[0];
      cyc(2);
      i_chan = 1'b1;
      cyc(3);
      chk("rx_data", 8'(v), {7'h00, rx});
      i_chan = 1'b0;
      cyc(2);
    end
    // Estimator modes and lengths; last entry uses up-minus-down as advised
    prev = 8'h00;
    for (int c = 0; c < 4; c++)
    begin
      rxfee_host_model_i.wr(`RXFEE_ADDR_FECTL, ctl[c]);
      cyc(2);
      repeat (nsym[c] - 1) sym(ups[c], 1);
      rdchk("result_hold", `RXFEE_ADDR_FERES, prev);
      sym(ups[c], 1);
      cyc(3);
      rdchk("result", `RXFEE_ADDR_FERES, res[c]);
      prev = res[c];
    end
    rxfee_host_model_i.wr(`RXFEE_ADDR_FECTL, 8'h0c);
    repeat (8) sym(1, 0);
    rdchk("result_off", `RXFEE_ADDR_FERES, prev);
    test_done();
  end

  initial
  begin
    repeat (40000) @(posedge clk_i);
    failures++;
    $display("[ERR] watchdog expected finish seen timeout");
    test_done();
  end
endmodule

bind rxfee_top rxfee_top_asserts rxfee_top_asserts_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .prog_clk_i(prog_clk_i), .prog_en_i(prog_en_i), .prog_data_o(prog_data_o),
  .prog_data_oe_o(prog_data_oe_o), .i_chan_i(i_chan_i), .q_chan_i(q_chan_i),
  .rx_data_o(rx_data_o), .amp_bypass_o(amp_bypass_o),
  .prefilter_cutoff_o(prefilter_cutoff_o), .filter_phase1_o(filter_phase1_o),
  .filter_phase2_o(filter_phase2_o));
